// [core/rcr_pkg.sv]
// Package: register map, field positions, reset values and carriers.
package rcr_pkg;

    // ************************************************************
    // Register offsets (7-bit register address).
    // ************************************************************
    localparam logic [6:0] ADDR_DIR_CHAN = 7'h00;
    localparam logic [6:0] ADDR_PWR_XTAL = 7'h01;
    localparam logic [6:0] ADDR_DATA_FN = 7'h02;
    localparam logic [6:0] ADDR_STR_CTL = 7'h03;
    localparam logic [6:0] ADDR_STR_VAL = 7'h04;
    localparam logic [6:0] ADDR_PKT_FMT = 7'h05;
    localparam logic [6:0] ADDR_MAP_LAST = 7'h18;

    // ************************************************************
    // Reset values.
    // ************************************************************
    localparam logic [7:0] RST_DIR_CHAN = 8'h28;
    localparam logic [7:0] RST_PWR_XTAL = 8'h03;
    localparam logic [7:0] RST_DATA_FN = 8'h78;
    localparam logic [7:0] RST_STR_CTL = 8'h87;
    localparam logic [7:0] RST_STR_VAL = 8'h20;
    localparam logic [7:0] RST_PKT_FMT = 8'h0F;

    // ************************************************************
    // Field positions.
    // ************************************************************
    localparam int BIT_DIRECTION = 7;
    localparam int BIT_BURST_MODE = 6;
    localparam int BIT_RATE = 5;
    localparam int BIT_SCRAMBLE = 4;
    localparam int BIT_CRC_EN = 3;
    localparam int BIT_CRC_KEEP = 0;
    localparam int BIT_REFRESH = 4;
    localparam int BIT_AGC = 5;
    localparam int BIT_GAIN = 4;
    localparam int BIT_ADDR_INS_N = 7;
    localparam int BIT_ADDR_OUT_N = 6;
    localparam int BIT_DEST_SRC = 5;

    // ************************************************************
    // Frame format and timing.
    // ************************************************************
    localparam int FRAME_BITS = 16;
    localparam int CRYSTAL_CODE_MAX = 4;

    // Decoded configuration handed to the radio core.
    typedef struct packed {
        logic transmit;
        logic [6:0] channel_number;
        logic [1:0] tx_output_level;
        logic [2:0] crystal_select;
        logic burst_mode;
        logic bit_rate_select;
        logic scramble_enable;
        logic crc_enable;
        logic crc_keep_on_error;
        logic analog_strength_refresh;
        logic [3:0] strength_threshold;
        logic auto_gain_enable;
        logic strength_gain_range;
        logic sender_addr_insert_n;
        logic sender_addr_output_n;
        logic dest_addr_source;
        logic [4:0] payload_len_m1;
    } rcr_cfg_s;

    // Byte stream to or from the packet FIFO.
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } rcr_byte_s;

endpackage

// [core/rcr_radio_config_register_bank.sv]
// Serial register bank and FIFO access steering of the radio transceiver.
`timescale 1ns/10ps

module rcr_radio_config_register_bank (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic serial_clock,
    input wire logic serial_select,
    input wire logic serial_data_line_in,
    output logic serial_data_line_out,
    output logic serial_data_line_oe,
    input wire logic [3:0] strength_level,
    output logic strength_above_pin,
    output rcr_pkg::rcr_cfg_s cfg,
    output rcr_pkg::rcr_byte_s fifo_wr,
    input wire rcr_pkg::rcr_byte_s fifo_rd,
    output logic fifo_rd_ack
);

    // ************************************************************
    // Link domain: shift register on the serial clock.
    // ************************************************************
    // The link clock only runs while the host clocks bits; the bit counter
    // restarts on the first serial edge after select changes level.
    logic [4:0] lk_cnt_r;
    logic [4:0] lk_cnt_nxt;
    logic [15:0] lk_sh_r;
    logic [15:0] lk_sh_nxt;
    logic lk_sel_r;
    logic lk_sel_nxt;
    logic lk_done_tgl_r;
    logic lk_done_tgl_nxt;
    logic [15:0] lk_word_r;
    logic [15:0] lk_word_nxt;
    logic [7:0] lk_tx_r;
    logic [7:0] lk_tx_nxt;
    logic lk_oe_r;
    logic lk_oe_nxt;
    logic [6:0] lk_addr_r;
    logic [6:0] lk_addr_nxt;
    logic lk_busy_r;
    logic lk_busy_nxt;

    // Read data registered in the system domain, and its level synchronised into the link domain.
    logic [7:0] rd_byte_r;
    logic [7:0] rd_byte_nxt;
    logic lk_fifo_read_s1_r;
    logic lk_fifo_read_s2_r;
    logic rcr_fifo_read_r;

    always_comb begin
        lk_cnt_nxt = lk_cnt_r;
        lk_sh_nxt = {lk_sh_r[14:0], serial_data_line_in};
        lk_sel_nxt = serial_select;
        lk_done_tgl_nxt = lk_done_tgl_r;
        lk_word_nxt = lk_word_r;
        lk_addr_nxt = lk_addr_r;
        lk_busy_nxt = serial_select;
        // A register access always restarts after select has dropped.
        if (lk_sel_r != serial_select
            || (serial_select && !lk_busy_r)) begin
            lk_cnt_nxt = 5'h01;
            lk_sh_nxt = {15'h0000, serial_data_line_in};
        end else if (serial_select) begin
            // Register frame: 16 bits, then frozen until select drops.
            if (lk_cnt_r < 5'(rcr_pkg::FRAME_BITS)) begin
                lk_cnt_nxt = lk_cnt_r + 5'h01;
            end
            if (lk_cnt_r == 5'h07) begin
                lk_addr_nxt = lk_sh_nxt[6:0];
            end
            if (lk_cnt_r == 5'(rcr_pkg::FRAME_BITS - 1)) begin
                lk_word_nxt = lk_sh_nxt;
                lk_done_tgl_nxt = ~lk_done_tgl_r;
            end
        end else begin
            // FIFO frame: one byte every eight bits.
            lk_cnt_nxt = (lk_cnt_r == 5'h07) ? 5'h00 : lk_cnt_r + 5'h01;
            if (lk_cnt_r == 5'h07) begin
                lk_word_nxt = {8'h00, lk_sh_nxt[7:0]};
                lk_done_tgl_nxt = ~lk_done_tgl_r;
            end
        end
    end

    always_ff @(posedge serial_clock) begin
        if (sys_rst) begin
            lk_cnt_r <= 5'h00;
            lk_sh_r <= 16'h0000;
            lk_sel_r <= 1'b0;
            lk_done_tgl_r <= 1'b0;
            lk_word_r <= 16'h0000;
            lk_addr_r <= 7'h00;
        end else begin
            lk_cnt_r <= lk_cnt_nxt;
            lk_sh_r <= lk_sh_nxt;
            lk_sel_r <= lk_sel_nxt;
            lk_done_tgl_r <= lk_done_tgl_nxt;
            lk_word_r <= lk_word_nxt;
            lk_addr_r <= lk_addr_nxt;
        end
    end

    // Select low clears the frame flag with the serial clock stopped, so
    // the next register access restarts its bit count.
    always_ff @(posedge serial_clock or negedge serial_select) begin
        if (!serial_select) begin
            lk_busy_r <= 1'b0;
        end else if (sys_rst) begin
            lk_busy_r <= 1'b0;
        end else begin
            lk_busy_r <= lk_busy_nxt;
        end
    end

    // Output shifting on the falling serial edge.
    always_comb begin
        lk_tx_nxt = {lk_tx_r[6:0], 1'b0};
        lk_oe_nxt = lk_oe_r;
        if (serial_select) begin
            if (lk_cnt_r == 5'h08 && !lk_sh_r[7]) begin
                lk_tx_nxt = rd_byte_r;
                lk_oe_nxt = 1'b1;
            end else if (lk_cnt_r == 5'(rcr_pkg::FRAME_BITS)) begin
                lk_oe_nxt = 1'b0;
            end
        end else if (lk_fifo_read_s2_r) begin
            lk_oe_nxt = 1'b1;
            if (lk_cnt_r == 5'h00) begin
                lk_tx_nxt = rd_byte_r;
            end
        end else begin
            lk_oe_nxt = 1'b0;
        end
    end

    always_ff @(negedge serial_clock) begin
        if (sys_rst) begin
            lk_tx_r <= 8'h00;
            lk_oe_r <= 1'b0;
            lk_fifo_read_s1_r <= 1'b0;
            lk_fifo_read_s2_r <= 1'b0;
        end else begin
            lk_tx_r <= lk_tx_nxt;
            lk_oe_r <= lk_oe_nxt;
            lk_fifo_read_s1_r <= rcr_fifo_read_r;
            lk_fifo_read_s2_r <= lk_fifo_read_s1_r;
        end
    end

    assign serial_data_line_out = lk_tx_r[7];
    assign serial_data_line_oe = lk_oe_r;

    // ************************************************************
    // System domain: frame crossing and register file.
    // ************************************************************
    logic sel_s1_r;
    logic sel_s2_r;
    logic tgl_s1_r;
    logic tgl_s2_r;
    logic tgl_s3_r;
    logic [3:0] lvl_s1_r;
    logic [3:0] lvl_s2_r;
    logic [7:0] reg_r [6];
    logic [7:0] reg_nxt [6];
    logic fifo_read_nxt;
    logic above_r;
    logic above_nxt;
    logic rd_ack_r;
    logic rd_ack_nxt;
    rcr_pkg::rcr_byte_s wr_r;
    rcr_pkg::rcr_byte_s wr_nxt;
    logic frame_done;
    logic [6:0] frame_addr;
    rcr_pkg::rcr_cfg_s cfg_r;
    rcr_pkg::rcr_cfg_s cfg_nxt;

    // Returns the reset value of a mapped register index.
    function automatic logic [7:0] reset_value(input int idx);
        case (idx)
            0: reset_value = rcr_pkg::RST_DIR_CHAN;
            1: reset_value = rcr_pkg::RST_PWR_XTAL;
            2: reset_value = rcr_pkg::RST_DATA_FN;
            3: reset_value = rcr_pkg::RST_STR_CTL;
            4: reset_value = rcr_pkg::RST_STR_VAL;
            default: reset_value = rcr_pkg::RST_PKT_FMT;
        endcase
    endfunction

    // True for an address that holds a register of this bank.
    function automatic logic is_mapped(input logic [6:0] addr);
        is_mapped = addr <= rcr_pkg::ADDR_PKT_FMT;
    endfunction

    // The word is stable for two clocks before its toggle is seen here.
    assign frame_done = tgl_s2_r ^ tgl_s3_r;
    assign frame_addr = lk_word_r[14:8];

    // Two-flop synchronisers; logic reads their second stage, and the toggle also its third.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sel_s1_r <= 1'b0;
            sel_s2_r <= 1'b0;
            tgl_s1_r <= 1'b0;
            tgl_s2_r <= 1'b0;
            tgl_s3_r <= 1'b0;
            lvl_s1_r <= 4'h0;
            lvl_s2_r <= 4'h0;
        end else begin
            sel_s1_r <= serial_select;
            sel_s2_r <= sel_s1_r;
            tgl_s1_r <= lk_done_tgl_r;
            tgl_s2_r <= tgl_s1_r;
            tgl_s3_r <= tgl_s2_r;
            lvl_s1_r <= strength_level;
            lvl_s2_r <= lvl_s1_r;
        end
    end

    // Register file.
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            reg_nxt[i] = reg_r[i];
        end
        if (frame_done && sel_s2_r && lk_word_r[15]
            && is_mapped(frame_addr)) begin
            reg_nxt[frame_addr[2:0]] = lk_word_r[7:0];
        end
        // The level field always tracks the converter output.
        reg_nxt[4][3:0] = lvl_s2_r;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            for (int i = 0; i < 6; i++) begin
                reg_r[i] <= reset_value(i);
            end
        end else begin
            for (int i = 0; i < 6; i++) begin
                reg_r[i] <= reg_nxt[i];
            end
        end
    end

    // FIFO strobes: one pulse per byte, direction from the chip mode.
    always_comb begin
        fifo_read_nxt = reg_r[2][rcr_pkg::BIT_BURST_MODE]
            & ~reg_r[0][rcr_pkg::BIT_DIRECTION];
        wr_nxt = '{valid: 1'b0, data: 8'h00};
        rd_ack_nxt = 1'b0;
        if (frame_done && !sel_s2_r
            && reg_r[2][rcr_pkg::BIT_BURST_MODE]) begin
            if (reg_r[0][rcr_pkg::BIT_DIRECTION]) begin
                wr_nxt = '{valid: 1'b1, data: lk_word_r[7:0]};
            end else begin
                rd_ack_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rcr_fifo_read_r <= 1'b0;
            rd_ack_r <= 1'b0;
            wr_r <= '{valid: 1'b0, data: 8'h00};
        end else begin
            rcr_fifo_read_r <= fifo_read_nxt;
            rd_ack_r <= rd_ack_nxt;
            wr_r <= wr_nxt;
        end
    end

    // Read byte for the link. The captured address stands from the
    // eighth serial edge, well ahead of the falling edge that loads it.
    always_comb begin
        rd_byte_nxt = rd_byte_r;
        if (sel_s2_r) begin
            if (is_mapped(lk_addr_r)) begin
                rd_byte_nxt = reg_r[lk_addr_r[2:0]];
            end else begin
                rd_byte_nxt = 8'h00;
            end
        end else if (fifo_rd.valid) begin
            rd_byte_nxt = fifo_rd.data;
        end
        above_nxt = lvl_s2_r > reg_r[3][3:0];
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rd_byte_r <= 8'h00;
            above_r <= 1'b0;
        end else begin
            rd_byte_r <= rd_byte_nxt;
            above_r <= above_nxt;
        end
    end

    // ************************************************************
    // Configuration fields.
    // ************************************************************
    always_comb begin
        cfg_nxt.transmit = reg_r[0][rcr_pkg::BIT_DIRECTION];
        cfg_nxt.channel_number = reg_r[0][6:0];
        cfg_nxt.tx_output_level = reg_r[1][4:3];
        cfg_nxt.crystal_select = reg_r[1][2:0];
        cfg_nxt.burst_mode = reg_r[2][rcr_pkg::BIT_BURST_MODE];
        cfg_nxt.bit_rate_select = reg_r[2][rcr_pkg::BIT_RATE];
        cfg_nxt.scramble_enable = reg_r[2][rcr_pkg::BIT_SCRAMBLE]
            & reg_r[2][rcr_pkg::BIT_BURST_MODE];
        cfg_nxt.crc_enable = reg_r[2][rcr_pkg::BIT_CRC_EN]
            & reg_r[2][rcr_pkg::BIT_BURST_MODE];
        cfg_nxt.crc_keep_on_error =
            reg_r[2][rcr_pkg::BIT_CRC_KEEP];
        cfg_nxt.analog_strength_refresh = reg_r[3][rcr_pkg::BIT_REFRESH]
            & ~reg_r[2][rcr_pkg::BIT_BURST_MODE];
        cfg_nxt.strength_threshold = reg_r[3][3:0];
        cfg_nxt.auto_gain_enable = reg_r[4][rcr_pkg::BIT_AGC]
            & ~reg_r[2][rcr_pkg::BIT_BURST_MODE];
        cfg_nxt.strength_gain_range =
            reg_r[4][rcr_pkg::BIT_GAIN];
        cfg_nxt.sender_addr_insert_n =
            reg_r[5][rcr_pkg::BIT_ADDR_INS_N];
        cfg_nxt.sender_addr_output_n =
            reg_r[5][rcr_pkg::BIT_ADDR_OUT_N];
        cfg_nxt.dest_addr_source =
            reg_r[5][rcr_pkg::BIT_DEST_SRC];
        cfg_nxt.payload_len_m1 = reg_r[5][4:0];
    end

    // The decoded fields leave the bank from flip-flops.
    always_ff @(posedge clock) begin
        cfg_r <= cfg_nxt;
    end

    assign cfg = cfg_r;
    assign strength_above_pin = above_r;
    assign fifo_wr = wr_r;
    assign fifo_rd_ack = rd_ack_r;

endmodule // rcr_radio_config_register_bank

// [dv/rcr_assertions.sv]
// Checker: port relations of the register bank.
`timescale 1ns/10ps
module rcr_assertions (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic serial_select,
    input wire logic serial_data_line_oe,
    input wire logic [3:0] strength_level,
    input wire logic strength_above_pin,
    input wire rcr_pkg::rcr_cfg_s cfg,
    input wire rcr_pkg::rcr_byte_s fifo_wr,
    input wire logic fifo_rd_ack
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    a_oe_has_cause: assert property (
        serial_data_line_oe |-> serial_select || !cfg.transmit)
        else $error("data line driven in transmit FIFO access");
    a_wr_one_pulse: assert property (
        fifo_wr.valid |-> (cfg.burst_mode && cfg.transmit) ##1 !fifo_wr.valid)
        else $error("bad FIFO write pulse");
    a_ack_one_pulse: assert property (
        fifo_rd_ack |-> (cfg.burst_mode && !cfg.transmit) ##1 !fifo_rd_ack)
        else $error("bad FIFO read acknowledge");
    a_above_set: assert property (
        (strength_level > cfg.strength_threshold) [*5] |-> strength_above_pin)
        else $error("indicator low above threshold");
    a_above_clear: assert property (
        (strength_level <= cfg.strength_threshold) [*5] |->
        !strength_above_pin)
        else $error("indicator high at or below threshold");
    a_burst_gating: assert property (
        cfg.scramble_enable || cfg.crc_enable |-> cfg.burst_mode)
        else $error("burst feature active in continuous mode");
    a_cont_gating: assert property (
        cfg.analog_strength_refresh || cfg.auto_gain_enable |->
        !cfg.burst_mode)
        else $error("continuous feature active in burst mode");
    a_reset_values: assert property (
        $fell(sys_rst) |-> cfg.channel_number == 7'h28 && !cfg.transmit &&
        cfg.crystal_select == 3'h3 && cfg.payload_len_m1 == 5'h0F)
        else $error("configuration not at reset values");

    c_fifo_write: cover property (fifo_wr.valid);
    c_fifo_read: cover property (fifo_rd_ack);
    c_above: cover property ($rose(strength_above_pin));
endmodule // rcr_assertions

bind rcr_radio_config_register_bank rcr_assertions u_chk (
    .clock(clock), .sys_rst(sys_rst), .serial_select(serial_select),
    .serial_data_line_oe(serial_data_line_oe),
    .strength_level(strength_level),
    .strength_above_pin(strength_above_pin), .cfg(cfg),
    .fifo_wr(fifo_wr), .fifo_rd_ack(fifo_rd_ack));

// [dv/rcr_host_model.sv]
// Host model: drives serial port frames into the register bank.
`timescale 1ns/10ps
module rcr_host_model #(
    parameter int SEL_SETUP_NS = 20000,
    parameter int HALF_NS = 80
) (
    output logic serial_clock,
    output logic serial_select,
    output logic serial_data_line_in,
    input wire logic serial_data_line_out,
    input wire logic serial_data_line_oe
);
    logic host_bit = 1'b1;

    initial begin
        serial_clock = 1'b0;
        serial_select = 1'b0;
    end

    // The device wins the wire while it drives it.
    assign serial_data_line_in = serial_data_line_oe ? serial_data_line_out
        : host_bit;

    task automatic idle_clocks(input int n);
        repeat (n) begin
            #(HALF_NS) serial_clock = 1'b1;
            #(HALF_NS) serial_clock = 1'b0;
        end
    endtask

    // Released bits toggle, so a missing device drive never reads right.
    task automatic frame(input logic sel, input int n,
        input logic [15:0] tx, input logic [15:0] rel,
        output logic [15:0] rx);
        rx = '0;
        serial_select = sel;
        #(SEL_SETUP_NS);
        for (int i = n - 1; i >= 0; i--) begin
            host_bit = rel[i] ? ~host_bit : tx[i];
            #(HALF_NS) serial_clock = 1'b1;
            rx[i] = serial_data_line_in;
            #(HALF_NS) serial_clock = 1'b0;
        end
        #(HALF_NS) serial_select = 1'b0;
        #(2 * HALF_NS);
    endtask
endmodule // rcr_host_model

// [dv/rcr_radio_config_register_bank_tb_top.sv]
// Testbench top: register, indicator and FIFO steering scenarios.
`timescale 1ns/10ps
module rcr_radio_config_register_bank_tb_top;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] level = 4'h0;
    rcr_pkg::rcr_byte_s fifo_rd = '0;
    rcr_pkg::rcr_byte_s fifo_wr;
    rcr_pkg::rcr_cfg_s cfg;
    logic sclk, sel, sdl_in, sdl_out, sdl_oe, above, ack;
    logic [15:0] wr_bytes = '0;
    logic [15:0] rx;
    int mismatches = 0;
    int compares = 0;
    int wr_count = 0;
    int ack_count = 0;
    int n;

    always #5 clock = ~clock;

    rcr_radio_config_register_bank uut (.clock(clock), .sys_rst(sys_rst),
        .serial_clock(sclk), .serial_select(sel),
        .serial_data_line_in(sdl_in), .serial_data_line_out(sdl_out),
        .serial_data_line_oe(sdl_oe), .strength_level(level),
        .strength_above_pin(above), .cfg(cfg), .fifo_wr(fifo_wr),
        .fifo_rd(fifo_rd), .fifo_rd_ack(ack));

    rcr_host_model host (.serial_clock(sclk), .serial_select(sel),
        .serial_data_line_in(sdl_in), .serial_data_line_out(sdl_out),
        .serial_data_line_oe(sdl_oe));

    always @(posedge clock) begin
        if (fifo_wr.valid === 1'b1) begin
            wr_count <= wr_count + 1;
            wr_bytes <= {wr_bytes[7:0], fifo_wr.data};
        end
        if (ack === 1'b1) begin
            ack_count <= ack_count + 1;
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [6:0] a, input logic [7:0] v);
        host.frame(1'b1, 16, {1'b1, a, v}, 16'h0000, rx);
    endtask

    task automatic read_check(input logic [6:0] a, input logic [7:0] exp);
        host.frame(1'b1, 16, {1'b0, a, 8'h00}, 16'h00FF, rx);
        check(rx[7:0], exp);
    endtask

    task automatic test_defaults;
        logic [7:0] exp [6] = '{8'h28, 8'h03, 8'h78, 8'h87, 8'h20, 8'h0F};
        for (int a = 0; a < 6; a++) begin
            read_check(7'(a), exp[a]);
        end
    endtask

    task automatic test_decode;
        reg_write(7'h00, 8'h81);
        reg_write(7'h01, 8'h1C);
        reg_write(7'h05, 8'hC0);
        check(8'({cfg.transmit, cfg.channel_number}), 8'h81);
        check(8'({cfg.tx_output_level, cfg.crystal_select}), 8'h1C);
        check(8'({cfg.sender_addr_insert_n, cfg.sender_addr_output_n,
            cfg.dest_addr_source, cfg.payload_len_m1}), 8'hC0);
    endtask

    task automatic test_modes;
        reg_write(7'h02, 8'h38);
        reg_write(7'h03, 8'h17);
        reg_write(7'h04, 8'h30);
        check(8'({cfg.burst_mode, cfg.bit_rate_select, cfg.scramble_enable,
            cfg.crc_enable, cfg.crc_keep_on_error}), 8'h08);
        check(8'({cfg.analog_strength_refresh, cfg.auto_gain_enable,
            cfg.strength_gain_range}), 8'h07);
        reg_write(7'h02, 8'h59);
        check(8'({cfg.burst_mode, cfg.bit_rate_select, cfg.scramble_enable,
            cfg.crc_enable, cfg.crc_keep_on_error}), 8'h17);
        check(8'({cfg.analog_strength_refresh, cfg.auto_gain_enable}),
            8'h00);
    endtask

    task automatic test_threshold;
        reg_write(7'h03, 8'h05);
        @(negedge clock);
        level = 4'h6;
        repeat (8) @(negedge clock);
        check(8'(above), 8'h01);
        read_check(7'h04, 8'h36);
        level = 4'h5;
        repeat (8) @(negedge clock);
        check(8'(above), 8'h00);
    endtask

    task automatic test_unmapped;
        reg_write(7'h06, 8'hFF);
        reg_write(7'h18, 8'hFF);
        read_check(7'h06, 8'h00);
        read_check(7'h18, 8'h00);
        read_check(7'h7F, 8'h00);
        read_check(7'h05, 8'hC0);
    endtask

    task automatic test_fifo_tx;
        n = wr_count;
        host.frame(1'b0, 16, 16'h3CA5, 16'h0000, rx);
        check(8'(wr_count - n), 8'h02);
        check(wr_bytes[15:8], 8'h3C);
        check(wr_bytes[7:0], 8'hA5);
        reg_write(7'h02, 8'h00);
        n = wr_count;
        host.frame(1'b0, 8, 16'h005A, 16'h0000, rx);
        check(8'(wr_count - n), 8'h00);
    endtask

    task automatic test_fifo_rx;
        reg_write(7'h00, 8'h7F);
        reg_write(7'h02, 8'h40);
        check(8'(cfg.channel_number), 8'h7F);
        @(negedge clock);
        fifo_rd = {1'b1, 8'hA5};
        n = ack_count;
        host.frame(1'b0, 16, 16'h0000, 16'hFFFF, rx);
        check(rx[7:0], 8'hA5);
        check(8'(ack_count - n), 8'h02);
    endtask

    task automatic print_verdict;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #950000;
        mismatches++;
        print_verdict();
    end

    initial begin
        fork
            repeat (16) @(negedge clock);
            host.idle_clocks(1);
        join
        sys_rst = 1'b0;
        repeat (2) @(negedge clock);
        test_defaults();
        test_decode();
        test_modes();
        test_threshold();
        test_unmapped();
        test_fifo_tx();
        test_fifo_rx();
        print_verdict();
    end
endmodule // rcr_radio_config_register_bank_tb_top
